// File: rtl/fsc_pkg.sv
// Constants for the fault_category_summary and communication flag block.
// Assumes a 32-bit APB bus whose word index is the register index.
package fsc_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [13:0] IDX_SUMMARY  = 14'h052D;
  localparam logic [13:0] IDX_HOST     = 14'h0530;
  localparam logic [13:0] IDX_CHAIN    = 14'h0531;
  localparam logic [13:0] IDX_MASK     = 14'h0540;
  localparam logic [13:0] IDX_FRST     = 14'h0541;
  localparam logic [13:0] IDX_IRQ_STAT = 14'h0542;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h0543;
  // ==========================================================
  // Summary bit positions
  localparam int SUM_PWR  = 0;
  localparam int SUM_SYS  = 1;
  localparam int SUM_VOLT = 2;
  localparam int SUM_TEMP = 3;
  localparam int SUM_COMM = 4;
  localparam int SUM_OTP  = 5;
  localparam int SUM_COMP = 6;
  localparam int SUM_PROT = 7;
  // ==========================================================
  // Host port flag positions
  localparam int HOST_STOP = 0;
  localparam int HOST_CLR  = 1;
  localparam int HOST_RC   = 2;
  localparam int HOST_RR   = 3;
  localparam int HOST_TR   = 4;
  localparam logic [7:0] HOST_USED = 8'h1F;
  // Chain port flag positions
  localparam int HS_BIT = 0;
  localparam int HS_RC  = 1;
  localparam int HS_RR  = 2;
  localparam int HS_TR  = 3;
  localparam int LS_BIT = 4;
  localparam int LS_RC  = 5;
  localparam int LS_RR  = 6;
  localparam int LS_TR  = 7;
  // ==========================================================
  // Category mask bit positions
  localparam int MB_PWR   = 0;
  localparam int MB_SYS   = 1;
  localparam int MB_OV    = 2;
  localparam int MB_UV    = 3;
  localparam int MB_OT    = 4;
  localparam int MB_UT    = 5;
  localparam int MB_COMP  = 6;
  localparam int MB_OTP   = 7;
  localparam int MB_PROT  = 8;
  localparam int MB_HOST  = 9;
  localparam int MB_CHAIN = 10;
  localparam int MB_HB    = 11;
  localparam int MB_TONE  = 12;
  localparam int MB_FCOMM = 13;
  // Fault reset and interrupt bit positions
  localparam int FR_HOST  = 0;
  localparam int FR_CHAIN = 1;
  localparam int IRQ_HOST = 0;
  localparam int IRQ_CHAIN = 1;
  localparam int IRQ_SUM  = 2;
  // ==========================================================
  // Reset values
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [13:0] RST_MASK  = 14'h0000;
  localparam logic [2:0]  RST_IRQ   = 3'h0;
endpackage

// File: rtl/fsc_fault_category_summary.sv
// Fault category summary, latched host and chain port communication
// flags, APB register slave and one level interrupt.
// Assumes fault sources run on I_SYS_CLK; only the wake pin is async.
`timescale 1ns/1ps
module fsc_fault_category_summary #(
  parameter int COMP_W = 16,
  parameter int OTP_W  = 8,
  parameter int TEMP_W = 16,
  parameter int VOLT_W = 16,
  parameter int SYS_W  = 8,
  parameter int PWR_W  = 24,
  parameter int PROT_W = 16
) (
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_RST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [15:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output logic [31:0]            PRDATA,
  input  wire logic [COMP_W-1:0] I_COMP_FAULTS,
  input  wire logic [OTP_W-1:0]  I_OTP_FAULTS,
  input  wire logic [TEMP_W-1:0] I_OT_FAULTS,
  input  wire logic [TEMP_W-1:0] I_UT_FAULTS,
  input  wire logic [VOLT_W-1:0] I_OV_FAULTS,
  input  wire logic [VOLT_W-1:0] I_UV_FAULTS,
  input  wire logic [SYS_W-1:0]  I_SYS_FAULTS,
  input  wire logic [PWR_W-1:0]  I_PWR_FAULTS,
  input  wire logic [PROT_W-1:0] I_PROT_FAULTS,
  input  wire logic              I_HEARTBEAT_TOO_FAST,
  input  wire logic              I_HEARTBEAT_MISSING,
  input  wire logic              I_TONE_DETECTED,
  input  wire logic              I_COMMUNICATION_SUMMARY_DETECTED,
  input  wire logic              I_HOST_TX_RESPONSE_FAULT,
  input  wire logic              I_HOST_RX_RESPONSE_FAULT,
  input  wire logic              I_HOST_RX_COMMAND_FAULT,
  input  wire logic              I_HOST_CLEAR_SEEN,
  input  wire logic              I_HOST_STOP_SEEN,
  input  wire logic              I_SLEEP_EXIT_PING,
  input  wire logic              I_MODE_ACTIVE,
  input  wire logic              I_MODE_SLEEP,
  input  wire logic              I_WAKE_PIN,
  input  wire logic              I_LOW_SIDE_TX_RESPONSE_FAULT,
  input  wire logic              I_LOW_SIDE_RX_RESPONSE_FAULT,
  input  wire logic              I_LOW_SIDE_RX_COMMAND_FAULT,
  input  wire logic              I_LOW_SIDE_BIT_FAULT,
  input  wire logic              I_HIGH_SIDE_TX_RESPONSE_FAULT,
  input  wire logic              I_HIGH_SIDE_RX_RESPONSE_FAULT,
  input  wire logic              I_HIGH_SIDE_RX_COMMAND_FAULT,
  input  wire logic              I_HIGH_SIDE_BIT_FAULT,
  output logic                   O_FAULT_OUTPUT_PIN_N,
  output logic                   O_IRQ
);

  // ==========================================================
  // Declarations
  logic [7:0]  host_reg;
  logic [7:0]  host_next;
  logic [7:0]  chain_reg;
  logic [7:0]  chain_next;
  logic [7:0]  sum_reg;
  logic [7:0]  sum_next;
  logic [13:0] mask_reg;
  logic [2:0]  irq_stat_reg;
  logic [2:0]  irq_stat_next;
  logic [2:0]  irq_mask_reg;
  logic [2:0]  wake_sync_reg;
  logic        wake_level_reg;
  logic        wake_rise;
  logic        wr_en;
  logic        rd_setup;
  logic [13:0] idx;
  logic        addr_ok;
  logic        hit;
  logic        clr_host;
  logic        clr_chain;
  logic [31:0] rd_mux;

  // ==========================================================
  // APB decode
  assign idx      = PADDR[15:2];
  assign addr_ok  = (PADDR[1:0] == 2'h0);
  assign hit      = addr_ok && (idx == fsc_pkg::IDX_SUMMARY || idx == fsc_pkg::IDX_HOST
                    || idx == fsc_pkg::IDX_CHAIN || idx == fsc_pkg::IDX_MASK
                    || idx == fsc_pkg::IDX_FRST || idx == fsc_pkg::IDX_IRQ_STAT
                    || idx == fsc_pkg::IDX_IRQ_MASK);
  // Write lands only at the access edge where ready is seen
  assign wr_en    = PSEL && PENABLE && PREADY && PWRITE && hit;
  assign rd_setup = PSEL && !PENABLE;
  assign clr_host  = wr_en && idx == fsc_pkg::IDX_FRST && PWDATA[fsc_pkg::FR_HOST];
  assign clr_chain = wr_en && idx == fsc_pkg::IDX_FRST && PWDATA[fsc_pkg::FR_CHAIN];

  // Ready one cycle after setup: every access has zero wait states
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= rd_setup;
      PSLVERR <= rd_setup && !hit;
    end
  end

  // Read mux; unmapped addresses read zero and flag an error
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_ok) begin
      unique case (idx)
        fsc_pkg::IDX_SUMMARY:  rd_mux[7:0]  = sum_reg;
        fsc_pkg::IDX_HOST:     rd_mux[7:0]  = host_reg;
        fsc_pkg::IDX_CHAIN:    rd_mux[7:0]  = chain_reg;
        fsc_pkg::IDX_MASK:     rd_mux[13:0] = mask_reg;
        fsc_pkg::IDX_IRQ_STAT: rd_mux[2:0]  = irq_stat_reg;
        fsc_pkg::IDX_IRQ_MASK: rd_mux[2:0]  = irq_mask_reg;
        default:               rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Read data is captured in setup so it is stable in access
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA <= rd_mux;
    end
  end

  // ==========================================================
  // Software controlled masks
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      mask_reg     <= fsc_pkg::RST_MASK;
      irq_mask_reg <= fsc_pkg::RST_IRQ;
    end else if (wr_en) begin
      if (idx == fsc_pkg::IDX_MASK) begin
        mask_reg <= PWDATA[13:0];
      end
      if (idx == fsc_pkg::IDX_IRQ_MASK) begin
        irq_mask_reg <= PWDATA[2:0];
      end
    end
  end

  // ==========================================================
  // Wake pin: three flops, a change counts when last two agree
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      wake_sync_reg  <= 3'h0;
      wake_level_reg <= 1'b0;
    end else begin
      wake_sync_reg <= {wake_sync_reg[1:0], I_WAKE_PIN};
      if (wake_sync_reg[1] == wake_sync_reg[2]) begin
        wake_level_reg <= wake_sync_reg[2];
      end
    end
  end
  assign wake_rise = wake_sync_reg[1] && wake_sync_reg[2] && !wake_level_reg;

  // ==========================================================
  // Host port flags; a detection in the clear cycle still sets
  always_comb begin
    host_next = clr_host ? fsc_pkg::RST_FLAGS : host_reg;
    if (I_HOST_TX_RESPONSE_FAULT) host_next[fsc_pkg::HOST_TR] = 1'b1;
    if (I_HOST_RX_RESPONSE_FAULT) host_next[fsc_pkg::HOST_RR] = 1'b1;
    if (I_HOST_RX_COMMAND_FAULT) host_next[fsc_pkg::HOST_RC] = 1'b1;
    if (I_HOST_CLEAR_SEEN || (I_SLEEP_EXIT_PING && (I_MODE_ACTIVE || I_MODE_SLEEP))
        || (wake_rise && I_MODE_ACTIVE)) begin
      host_next[fsc_pkg::HOST_CLR] = 1'b1;
    end
    if (I_HOST_STOP_SEEN || (I_SLEEP_EXIT_PING && I_MODE_ACTIVE)) begin
      host_next[fsc_pkg::HOST_STOP] = 1'b1;
    end
    host_next = host_next & fsc_pkg::HOST_USED;
  end

  // Chain port flags, low side upper nibble, high side lower
  always_comb begin
    chain_next = clr_chain ? fsc_pkg::RST_FLAGS : chain_reg;
    if (I_LOW_SIDE_TX_RESPONSE_FAULT) chain_next[fsc_pkg::LS_TR] = 1'b1;
    if (I_LOW_SIDE_RX_RESPONSE_FAULT) chain_next[fsc_pkg::LS_RR] = 1'b1;
    if (I_LOW_SIDE_RX_COMMAND_FAULT) chain_next[fsc_pkg::LS_RC] = 1'b1;
    if (I_LOW_SIDE_BIT_FAULT) chain_next[fsc_pkg::LS_BIT] = 1'b1;
    if (I_HIGH_SIDE_TX_RESPONSE_FAULT) chain_next[fsc_pkg::HS_TR] = 1'b1;
    if (I_HIGH_SIDE_RX_RESPONSE_FAULT) chain_next[fsc_pkg::HS_RR] = 1'b1;
    if (I_HIGH_SIDE_RX_COMMAND_FAULT) chain_next[fsc_pkg::HS_RC] = 1'b1;
    if (I_HIGH_SIDE_BIT_FAULT) chain_next[fsc_pkg::HS_BIT] = 1'b1;
  end

  // flags latch until the fault reset write
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      host_reg  <= fsc_pkg::RST_FLAGS;
      chain_reg <= fsc_pkg::RST_FLAGS;
    end else begin
      host_reg  <= host_next;
      chain_reg <= chain_next;
    end
  end

  // ==========================================================
  // Summary: masked OR per category, rebuilt every cycle
  always_comb begin
    sum_next = 8'h00;
    sum_next[fsc_pkg::SUM_COMP] = !mask_reg[fsc_pkg::MB_COMP] && (|I_COMP_FAULTS);
    sum_next[fsc_pkg::SUM_OTP]  = !mask_reg[fsc_pkg::MB_OTP] && (|I_OTP_FAULTS);
    sum_next[fsc_pkg::SUM_COMM] = (!mask_reg[fsc_pkg::MB_HOST] && (|host_reg))
      || (!mask_reg[fsc_pkg::MB_CHAIN] && (|chain_reg))
      || (!mask_reg[fsc_pkg::MB_HB] && (I_HEARTBEAT_TOO_FAST || I_HEARTBEAT_MISSING))
      || (!mask_reg[fsc_pkg::MB_TONE] && I_TONE_DETECTED)
      || (!mask_reg[fsc_pkg::MB_FCOMM] && I_COMMUNICATION_SUMMARY_DETECTED);
    sum_next[fsc_pkg::SUM_TEMP] = (!mask_reg[fsc_pkg::MB_OT] && (|I_OT_FAULTS))
      || (!mask_reg[fsc_pkg::MB_UT] && (|I_UT_FAULTS));
    sum_next[fsc_pkg::SUM_VOLT] = (!mask_reg[fsc_pkg::MB_OV] && (|I_OV_FAULTS))
      || (!mask_reg[fsc_pkg::MB_UV] && (|I_UV_FAULTS));
    sum_next[fsc_pkg::SUM_SYS]  = !mask_reg[fsc_pkg::MB_SYS] && (|I_SYS_FAULTS);
    sum_next[fsc_pkg::SUM_PWR]  = !mask_reg[fsc_pkg::MB_PWR] && (|I_PWR_FAULTS);
    sum_next[fsc_pkg::SUM_PROT] = !mask_reg[fsc_pkg::MB_PROT] && (|I_PROT_FAULTS);
  end

  // recomputed each cycle; pin follows the same bits
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      sum_reg              <= 8'h00;
      O_FAULT_OUTPUT_PIN_N <= 1'b1;
    end else begin
      sum_reg              <= sum_next;
      O_FAULT_OUTPUT_PIN_N <= !(|sum_next);
    end
  end

  // ==========================================================
  // Interrupt status: sticky, write one to clear, set beats clear
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_en && idx == fsc_pkg::IDX_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~PWDATA[2:0];
    end
    if (host_next != host_reg && (|(host_next & ~host_reg))) begin
      irq_stat_next[fsc_pkg::IRQ_HOST] = 1'b1;
    end
    if (|(chain_next & ~chain_reg)) begin
      irq_stat_next[fsc_pkg::IRQ_CHAIN] = 1'b1;
    end
    if (|(sum_next & ~sum_reg)) begin
      irq_stat_next[fsc_pkg::IRQ_SUM] = 1'b1;
    end
  end

  // Level interrupt, registered so it comes straight from a flop
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      irq_stat_reg <= fsc_pkg::RST_IRQ;
      O_IRQ        <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      O_IRQ        <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  AST_COMP_SUM: assert property (
    (!mask_reg[fsc_pkg::MB_COMP] && (|I_COMP_FAULTS)) |=> sum_reg[fsc_pkg::SUM_COMP])
    else $error("Comparison summary missed");
  AST_OTP_MASKED: assert property (
    mask_reg[fsc_pkg::MB_OTP] |=> !sum_reg[fsc_pkg::SUM_OTP])
    else $error("Masked OTP summary set");
  AST_COMM_HOST: assert property (
    (!mask_reg[fsc_pkg::MB_HOST] && (|host_reg)) |=> sum_reg[fsc_pkg::SUM_COMM])
    else $error("Comm summary missed host flag");
  AST_TEMP_SUM: assert property (
    (!mask_reg[fsc_pkg::MB_UT] && (|I_UT_FAULTS)) |=> sum_reg[fsc_pkg::SUM_TEMP])
    else $error("Temperature summary missed");
  AST_VOLT_SUM: assert property (
    (!mask_reg[fsc_pkg::MB_OV] && (|I_OV_FAULTS)) |=> sum_reg[fsc_pkg::SUM_VOLT])
    else $error("Voltage summary missed");
  AST_SYS_CLEAR: assert property (
    !(|I_SYS_FAULTS) |=> !sum_reg[fsc_pkg::SUM_SYS])
    else $error("System summary without fault");
  AST_PWR_SUM: assert property (
    (!mask_reg[fsc_pkg::MB_PWR] && (|I_PWR_FAULTS)) |=> sum_reg[fsc_pkg::SUM_PWR])
    else $error("Power summary missed");
  AST_HOST_TX: assert property (
    (I_HOST_TX_RESPONSE_FAULT ##1 !clr_host) |-> host_reg[fsc_pkg::HOST_TR] [*2])
    else $error("Host transmit flag not latched");
  AST_STOP_PING: assert property (
    (I_SLEEP_EXIT_PING && I_MODE_ACTIVE) |=> host_reg[fsc_pkg::HOST_STOP])
    else $error("Stop flag missed active ping");
  AST_LS_BIT: assert property (
    I_LOW_SIDE_BIT_FAULT |=> chain_reg[fsc_pkg::LS_BIT])
    else $error("Low side bit flag missed");
  AST_HS_RC: assert property (
    I_HIGH_SIDE_RX_COMMAND_FAULT |=> chain_reg[fsc_pkg::HS_RC])
    else $error("High side command flag missed");
  // Further flag sources, then comm, pin, latch and reserved bit checks, one check per rule
  AST_HOST_RR: assert property (
    I_HOST_RX_RESPONSE_FAULT |=> host_reg[fsc_pkg::HOST_RR])
    else $error("Host response receive flag missed");
  AST_HOST_RC: assert property (
    I_HOST_RX_COMMAND_FAULT |=> host_reg[fsc_pkg::HOST_RC])
    else $error("Host command receive flag missed");
  AST_CLR_WAKE: assert property (
    (wake_rise && I_MODE_ACTIVE) |=> host_reg[fsc_pkg::HOST_CLR])
    else $error("Clear flag missed wake pin");
  AST_LS_TR: assert property (
    I_LOW_SIDE_TX_RESPONSE_FAULT |=> chain_reg[fsc_pkg::LS_TR])
    else $error("Low side transmit flag missed");
  AST_HS_BIT: assert property (
    I_HIGH_SIDE_BIT_FAULT |=> chain_reg[fsc_pkg::HS_BIT])
    else $error("High side bit flag missed");
  AST_COMM_CHAIN: assert property (
    (!mask_reg[fsc_pkg::MB_CHAIN] && (|chain_reg)) |=> sum_reg[fsc_pkg::SUM_COMM])
    else $error("Comm summary missed chain flag");
  AST_PIN_MIRROR: assert property (
    O_FAULT_OUTPUT_PIN_N == !(|sum_reg))
    else $error("Pin and summary disagree");
  AST_LATCH: assert property (
    (host_reg[fsc_pkg::HOST_RC] && !clr_host) |=> host_reg[fsc_pkg::HOST_RC])
    else $error("Host flag dropped without reset");
  AST_RSVD: assert property (
    host_reg[7:5] == 3'h0)
    else $error("Reserved host bits set");

  COV_COMM_SUM: cover property (sum_reg[fsc_pkg::SUM_COMM] ##1 !sum_reg[fsc_pkg::SUM_COMM]);
  COV_CLR_RACE: cover property (clr_host && I_HOST_RX_COMMAND_FAULT);
  COV_IRQ: cover property (!O_IRQ ##1 O_IRQ);
  COV_WAKE: cover property (wake_rise && I_MODE_ACTIVE);

endmodule // fsc_fault_category_summary

// File: tb/fsc_fault_category_summary_bench.sv
// Self-checking bench for the fault_category_summary and communication flag block.
// Assumes the design answers APB with one wait-free access cycle.
`timescale 1ns/1ps
module fsc_fault_category_summary_bench;
  // ==========================================================
  // Stimulus signals and bench state
  typedef struct {int code; int mbit; int sbit;} fsc_sum_row_t;
  typedef struct {int code; logic [7:0] flags;} fsc_evt_row_t;
  logic        sys_clk  = 1'b0;
  logic        rst      = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [15:0] paddr    = 16'h0000;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic [15:0] comp_f   = 16'h0000;
  logic [7:0]  otp_f    = 8'h00;
  logic [15:0] ot_f     = 16'h0000;
  logic [15:0] ut_f     = 16'h0000;
  logic [15:0] ov_f     = 16'h0000;
  logic [15:0] uv_f     = 16'h0000;
  logic [7:0]  sys_f    = 8'h00;
  logic [23:0] pwr_f    = 24'h000000;
  logic [15:0] prot_f   = 16'h0000;
  logic [3:0]  comm3    = 4'h0;   // Fast, missing, tone, communication_summary
  logic [4:0]  host_ev  = 5'h00;  // Index equals host flag position
  logic [7:0]  chain_ev = 8'h00;  // Index equals chain flag position
  logic        ping     = 1'b0;
  logic        act      = 1'b0;
  logic        slp      = 1'b0;
  logic        wake     = 1'b0;
  logic        pin_n;
  logic        irq;
  logic        last_err;
  int          fail_count = 0;
  int          checks     = 0;
  logic [13:0] rst_idx [6] = '{fsc_pkg::IDX_SUMMARY, fsc_pkg::IDX_HOST, fsc_pkg::IDX_CHAIN,
                              fsc_pkg::IDX_MASK, fsc_pkg::IDX_IRQ_STAT, fsc_pkg::IDX_IRQ_MASK};
  // Source code, mask bit, summary bit
  fsc_sum_row_t sum_rows [13] = '{
    '{0, fsc_pkg::MB_PWR, fsc_pkg::SUM_PWR}, '{1, fsc_pkg::MB_SYS, fsc_pkg::SUM_SYS},
    '{2, fsc_pkg::MB_OV, fsc_pkg::SUM_VOLT}, '{3, fsc_pkg::MB_UV, fsc_pkg::SUM_VOLT},
    '{4, fsc_pkg::MB_OT, fsc_pkg::SUM_TEMP}, '{5, fsc_pkg::MB_UT, fsc_pkg::SUM_TEMP},
    '{6, fsc_pkg::MB_COMP, fsc_pkg::SUM_COMP}, '{7, fsc_pkg::MB_OTP, fsc_pkg::SUM_OTP},
    '{8, fsc_pkg::MB_PROT, fsc_pkg::SUM_PROT}, '{9, fsc_pkg::MB_HB, fsc_pkg::SUM_COMM},
    '{10, fsc_pkg::MB_HB, fsc_pkg::SUM_COMM}, '{11, fsc_pkg::MB_TONE, fsc_pkg::SUM_COMM},
    '{12, fsc_pkg::MB_FCOMM, fsc_pkg::SUM_COMM}};
  // Codes 0..4 host, 5 ping active, 6 ping asleep, 7 wake, 8..15 chain
  fsc_evt_row_t evt_rows [16] = '{
    '{0, 8'h01}, '{1, 8'h02}, '{2, 8'h04}, '{3, 8'h08}, '{4, 8'h10}, '{5, 8'h03},
    '{6, 8'h02}, '{7, 8'h02}, '{8, 8'h01}, '{9, 8'h02}, '{10, 8'h04}, '{11, 8'h08},
    '{12, 8'h10}, '{13, 8'h20}, '{14, 8'h40}, '{15, 8'h80}};

  // ==========================================================
  // Clock and device under test
  initial forever #12.5 sys_clk = ~sys_clk;

  fsc_fault_category_summary i_dut (
    .I_SYS_CLK(sys_clk), .I_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata),
    .I_COMP_FAULTS(comp_f), .I_OTP_FAULTS(otp_f), .I_OT_FAULTS(ot_f), .I_UT_FAULTS(ut_f),
    .I_OV_FAULTS(ov_f), .I_UV_FAULTS(uv_f), .I_SYS_FAULTS(sys_f), .I_PWR_FAULTS(pwr_f),
    .I_PROT_FAULTS(prot_f), .I_HEARTBEAT_TOO_FAST(comm3[0]), .I_HEARTBEAT_MISSING(comm3[1]),
    .I_TONE_DETECTED(comm3[2]), .I_COMMUNICATION_SUMMARY_DETECTED(comm3[3]),
    .I_HOST_TX_RESPONSE_FAULT(host_ev[4]), .I_HOST_RX_RESPONSE_FAULT(host_ev[3]),
    .I_HOST_RX_COMMAND_FAULT(host_ev[2]), .I_HOST_CLEAR_SEEN(host_ev[1]),
    .I_HOST_STOP_SEEN(host_ev[0]), .I_SLEEP_EXIT_PING(ping), .I_MODE_ACTIVE(act),
    .I_MODE_SLEEP(slp), .I_WAKE_PIN(wake),
    .I_LOW_SIDE_TX_RESPONSE_FAULT(chain_ev[7]), .I_LOW_SIDE_RX_RESPONSE_FAULT(chain_ev[6]),
    .I_LOW_SIDE_RX_COMMAND_FAULT(chain_ev[5]), .I_LOW_SIDE_BIT_FAULT(chain_ev[4]),
    .I_HIGH_SIDE_TX_RESPONSE_FAULT(chain_ev[3]), .I_HIGH_SIDE_RX_RESPONSE_FAULT(chain_ev[2]),
    .I_HIGH_SIDE_RX_COMMAND_FAULT(chain_ev[1]), .I_HIGH_SIDE_BIT_FAULT(chain_ev[0]),
    .O_FAULT_OUTPUT_PIN_N(pin_n), .O_IRQ(irq));

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [15:0] ba(input logic [13:0] idx);
    return {idx, 2'b00};
  endfunction

  // One APB transfer; the wait for pready is bounded so a hang ends the run
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin fail_count++; complete_run(); end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] v;
    apb(1'b1, a, d, v);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] v;
    apb(1'b0, a, 32'h0000_0000, v);
    check(v, exp);
  endtask

  // Raise only the top bit of a wide source, so a narrowed OR shows up
  task automatic set_src(input int code, input logic on);
    case (code)
      0: pwr_f <= on ? 24'h800000 : 24'h000000;
      1: sys_f <= on ? 8'h80 : 8'h00;
      2: ov_f <= on ? 16'h8000 : 16'h0000;
      3: uv_f <= on ? 16'h8000 : 16'h0000;
      4: ot_f <= on ? 16'h8000 : 16'h0000;
      5: ut_f <= on ? 16'h8000 : 16'h0000;
      6: comp_f <= on ? 16'h8000 : 16'h0000;
      7: otp_f <= on ? 8'h80 : 8'h00;
      8: prot_f <= on ? 16'h8000 : 16'h0000;
      default: comm3[code-9] <= on;
    endcase
  endtask

  // One-cycle event, wake pin held three cycles; wait covers the wake pin synchroniser
  task automatic pulse(input int code);
    @(posedge sys_clk);
    act <= (code != 6);
    slp <= (code == 6);
    if (code < 5) host_ev[code] <= 1'b1;
    else if (code == 7) wake <= 1'b1;
    else if (code < 8) ping <= 1'b1;
    else chain_ev[code-8] <= 1'b1;
    @(posedge sys_clk);
    host_ev <= 5'h00; chain_ev <= 8'h00; ping <= 1'b0;
    // Pin must stay up until the last two sync stages agree
    repeat (2) @(posedge sys_clk);
    wake <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] rdv;
    logic        hostsel;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check({31'h0, pin_n}, 32'h1);
    check({31'h0, irq}, 32'h0);
    foreach (rst_idx[i]) rd_chk(ba(rst_idx[i]), 32'h0);
    // Each category alone, unmasked then masked, then source removed
    foreach (sum_rows[i]) begin
      for (int m = 0; m < 2; m++) begin
        wr(ba(fsc_pkg::IDX_MASK), (m == 1) ? (32'h1 << sum_rows[i].mbit) : 32'h0);
        set_src(sum_rows[i].code, 1'b1);
        repeat (2) @(posedge sys_clk);
        rd_chk(ba(fsc_pkg::IDX_SUMMARY), (m == 1) ? 32'h0 : (32'h1 << sum_rows[i].sbit));
        check({31'h0, pin_n}, (m == 1) ? 32'h1 : 32'h0);
        set_src(sum_rows[i].code, 1'b0);
        repeat (2) @(posedge sys_clk);
        rd_chk(ba(fsc_pkg::IDX_SUMMARY), 32'h0);
      end
    end
    // Every event source latches its own flag until the fault reset
    wr(ba(fsc_pkg::IDX_MASK), 32'h0);
    foreach (evt_rows[i]) begin
      hostsel = (evt_rows[i].code < 8);
      pulse(evt_rows[i].code);
      rd_chk(ba(hostsel ? fsc_pkg::IDX_HOST : fsc_pkg::IDX_CHAIN), {24'h0, evt_rows[i].flags});
      rd_chk(ba(fsc_pkg::IDX_SUMMARY), 32'h10);
      wr(ba(fsc_pkg::IDX_FRST), hostsel ? 32'h1 : 32'h2);
      rd_chk(ba(hostsel ? fsc_pkg::IDX_HOST : fsc_pkg::IDX_CHAIN), 32'h0);
    end
    // Host and chain masks keep latched flags out of the comm summary
    wr(ba(fsc_pkg::IDX_MASK), 32'h600);
    pulse(2);
    pulse(8);
    rd_chk(ba(fsc_pkg::IDX_SUMMARY), 32'h0);
    wr(ba(fsc_pkg::IDX_MASK), 32'h1 << fsc_pkg::MB_CHAIN);
    rd_chk(ba(fsc_pkg::IDX_SUMMARY), 32'h10);
    wr(ba(fsc_pkg::IDX_MASK), 32'h1 << fsc_pkg::MB_HOST);
    rd_chk(ba(fsc_pkg::IDX_SUMMARY), 32'h10);
    // Fault reset and a new detection in one cycle: the detection wins
    fork
      wr(ba(fsc_pkg::IDX_FRST), 32'h3);
      begin
        repeat (2) @(posedge sys_clk);
        host_ev[fsc_pkg::HOST_RC] <= 1'b1;
        @(posedge sys_clk);
        host_ev <= 5'h00;
      end
    join
    rd_chk(ba(fsc_pkg::IDX_HOST), 32'h04);
    rd_chk(ba(fsc_pkg::IDX_CHAIN), 32'h0);
    wr(ba(fsc_pkg::IDX_FRST), 32'h1);
    wr(ba(fsc_pkg::IDX_MASK), 32'h0);
    // Interrupt raised, cleared by writing one, then masked
    wr(ba(fsc_pkg::IDX_IRQ_STAT), 32'h7);
    wr(ba(fsc_pkg::IDX_IRQ_MASK), 32'h1);
    pulse(4);
    check({31'h0, irq}, 32'h1);
    rd_chk(ba(fsc_pkg::IDX_IRQ_STAT), 32'h5);
    wr(ba(fsc_pkg::IDX_IRQ_STAT), 32'h1);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    rd_chk(ba(fsc_pkg::IDX_IRQ_STAT), 32'h4);
    wr(ba(fsc_pkg::IDX_FRST), 32'h1);
    wr(ba(fsc_pkg::IDX_IRQ_STAT), 32'h4);
    wr(ba(fsc_pkg::IDX_IRQ_MASK), 32'h0);
    pulse(4);
    check({31'h0, irq}, 32'h0);
    rd_chk(ba(fsc_pkg::IDX_IRQ_STAT), 32'h5);
    // Refused accesses: unmapped, misaligned, write to a read-only flag
    apb(1'b0, 16'h1600, 32'h0, rdv);
    check(rdv, 32'h0);
    check({31'h0, last_err}, 32'h1);
    apb(1'b0, ba(fsc_pkg::IDX_HOST) | 16'h0002, 32'h0, rdv);
    check({31'h0, last_err}, 32'h1);
    wr(ba(fsc_pkg::IDX_HOST), 32'hFF);
    check({31'h0, last_err}, 32'h0);
    rd_chk(ba(fsc_pkg::IDX_HOST), 32'h10);
    // Reset in mid-run drops a latched flag and frees the pin
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check({31'h0, pin_n}, 32'h1);
    rd_chk(ba(fsc_pkg::IDX_HOST), 32'h0);
    complete_run();
  end
endmodule // fsc_fault_category_summary_bench
